// ==== hdl/ipb_pkg.sv ====
/*
 Shared constants and types of the interrupt priority and break controller.
 Assumes a 32-bit APB slave port and one 250 MHz clock domain.
*/
package ipb_pkg;
  // APB word offsets
  localparam logic [7:0] OFS_PEND_MID   = 8'h00;
  localparam logic [7:0] OFS_PEND_HIGH  = 8'h04;
  localparam logic [7:0] OFS_BRK_CTRL   = 8'h08;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h0C;
  localparam logic [7:0] OFS_EVT_MASK   = 8'h10;
  localparam logic [7:0] OFS_MODE_STAT  = 8'h14;

  // Interrupt source numbering
  localparam int NUM_SRC = 21;
  localparam int MID_LO  = 7;
  localparam int MID_HI  = 14;
  localparam int HIGH_LO = 15;
  localparam int HIGH_HI = 21;
  localparam int RST_SRC_W = 4;

  // Vector addresses
  localparam logic [15:0] VEC_RESERVED = 16'hFFD0;
  localparam logic [15:0] VEC_SRC1     = 16'hFFFA;
  localparam logic [15:0] VEC_SWI      = 16'hFFFC;
  localparam logic [15:0] VEC_RESET    = 16'hFFFE;

  // Event status bits
  localparam int EV_BREAK = 0;
  localparam int EV_WAIT  = 1;
  localparam int EV_STOP  = 2;
  localparam int EV_WAKE  = 3;
  localparam int EV_W     = 4;

  // Reset values
  localparam logic            BREAK_CLEAR_ENABLE_RST     = 1'b0;
  localparam logic [EV_W-1:0] EVT_MASK_RST = 4'h0;

  typedef enum logic [2:0] {
    LP_RUN  = 3'b001,
    LP_WAIT = 3'b010,
    LP_STOP = 3'b100
  } ipb_lp_t;

  typedef enum logic [4:0] {
    EX_NONE = 5'b00001,
    EX_HW   = 5'b00010,
    EX_SWI  = 5'b00100,
    EX_BRK  = 5'b01000,
    EX_RST  = 5'b10000
  } ipb_exc_t;

  typedef struct packed {
    logic instr_end;
    logic swi_exec;
    logic wait_exec;
    logic stop_exec;
    logic vec_ack;
    logic break_exit;
    logic i_mask;
  } ipb_cpu_in_t;

  typedef struct packed {
    logic        exc_pending;
    logic [15:0] vector;
    logic        clock_hold;
    logic        clear_i_mask;
    logic        break_state;
  } ipb_cpu_out_t;
endpackage : ipb_pkg

// ==== hdl/ipb_ctrl.sv ====
/*
 Interrupt bookkeeping, exception priority, break entry, break flag
 protection and wait/stop entry. Assumes all inputs come from logic on
 clk; the CPU core reads cpu_out and reports instruction events on cpu_in.
*/
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ipb_ctrl (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  // APB slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [7:0]                     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // Request sources
  input  wire logic [ipb_pkg::NUM_SRC:1]      src_req,
  input  wire logic [ipb_pkg::RST_SRC_W-1:0]  reset_src,
  input  wire logic                           brk_req,
  // CPU core
  input  wire ipb_pkg::ipb_cpu_in_t           cpu_in,
  output ipb_pkg::ipb_cpu_out_t               cpu_out,
  // Peripheral flag clearing and interrupt
  output logic                                flag_clear_allow,
  output logic                                irq
);
  import ipb_pkg::*;

  function automatic logic [4:0] lowest_src(input logic [NUM_SRC:1] r);
    logic [4:0] n;
    n = 5'd0;
    for (int i = NUM_SRC; i >= 1; i--)
      if (r[i]) n = 5'(i);
    return n;
  endfunction : lowest_src

  function automatic logic [15:0] src_vector(input logic [4:0] n);
    return VEC_SRC1 - 16'({n - 5'd1, 1'b0});
  endfunction : src_vector

  ipb_exc_t        kind;
  ipb_exc_t        next_kind;
  ipb_exc_t        arb_kind;
  ipb_lp_t         lp;
  ipb_lp_t         next_lp;
  logic [15:0]     vector;
  logic [15:0]     arb_vec;
  logic            pend;
  logic            clock_hold;
  logic            clear_i_mask;
  logic            break_state;
  logic            next_break;
  logic            break_clear_enable;
  logic            next_break_clear_enable;
  logic            i_mask_q;
  logic            i_clr_edge;
  logic            reset_any;
  logic            take;
  logic            release_x;
  logic [4:0]      hw_idx;
  logic            hw_ok;
  logic [EV_W-1:0] evt_status;
  logic [EV_W-1:0] evt_mask;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] next_status;
  logic            setup;
  logic            wr;
  logic            rd;
  logic            mapped;
  logic [31:0]     rdata;

  assign cpu_out = '{exc_pending: pend, vector: vector, clock_hold: clock_hold,
                     clear_i_mask: clear_i_mask, break_state: break_state};

  // Arbitration
  assign reset_any  = |reset_src;
  assign hw_idx     = lowest_src(src_req);
  assign hw_ok      = (hw_idx != 5'd0) && !cpu_in.i_mask;
  assign i_clr_edge = i_mask_q && !cpu_in.i_mask;

  always_comb begin
    if (reset_any) begin
      arb_kind = EX_RST;
      arb_vec  = VEC_RESET;
    end else if (brk_req && !break_state) begin
      arb_kind = EX_BRK;
      arb_vec  = VEC_SWI;
    end else if (cpu_in.swi_exec) begin
      arb_kind = EX_SWI;
      arb_vec  = VEC_SWI;
    end else if (hw_ok) begin
      arb_kind = EX_HW;
      arb_vec  = src_vector(hw_idx);
    end else begin
      arb_kind = EX_NONE;
      arb_vec  = VEC_RESERVED;
    end
  end

  // Latch only when idle; reset always wins
  assign take = reset_any ||
                (kind == EX_NONE && arb_kind != EX_NONE &&
                 (cpu_in.instr_end || cpu_in.swi_exec || brk_req || lp != LP_RUN));
  assign release_x = cpu_in.vec_ack || (i_clr_edge && kind == EX_HW);

  always_comb begin
    if (take)
      next_kind = arb_kind;
    else if (release_x)
      next_kind = EX_NONE;
    else
      next_kind = kind;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      kind   <= EX_NONE;
      pend   <= 1'b0;
      vector <= VEC_RESERVED;
    end else begin
      kind <= next_kind;
      pend <= next_kind != EX_NONE;
      if (take)
        vector <= arb_vec;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      i_mask_q <= 1'b1;
    else
      i_mask_q <= cpu_in.i_mask;
  end

  // Break state and flag protection
  always_comb begin
    if (take && arb_kind == EX_BRK)
      next_break = 1'b1;
    else if (cpu_in.break_exit || reset_any)
      next_break = 1'b0;
    else
      next_break = break_state;
  end

  assign next_break_clear_enable = (wr && paddr == OFS_BRK_CTRL) ? pwdata[0] : break_clear_enable;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      break_state      <= 1'b0;
      break_clear_enable             <= BREAK_CLEAR_ENABLE_RST;
      flag_clear_allow <= 1'b1;
    end else begin
      break_state      <= next_break;
      break_clear_enable             <= next_break_clear_enable;
      flag_clear_allow <= !next_break || next_break_clear_enable;
    end
  end

  // Low-power modes
  always_comb begin
    next_lp = lp;
    unique case (lp)
      LP_RUN: begin
        if (cpu_in.wait_exec)
          next_lp = LP_WAIT;
        else if (cpu_in.stop_exec)
          next_lp = LP_STOP;
      end
      LP_WAIT, LP_STOP: begin
        if (take)
          next_lp = LP_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lp           <= LP_RUN;
      clock_hold   <= 1'b0;
      clear_i_mask <= 1'b0;
    end else begin
      lp           <= next_lp;
      clock_hold   <= next_lp != LP_RUN;
      clear_i_mask <= lp == LP_RUN &&
                      (cpu_in.wait_exec || cpu_in.stop_exec);
    end
  end

  // APB access
  assign setup = psel && !penable;
  assign wr    = psel && penable && pready && pwrite && !pslverr;
  assign rd    = psel && penable && pready && !pwrite && !pslverr;

  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      OFS_PEND_MID:   rdata = 32'(src_req[MID_HI:MID_LO]);
      OFS_PEND_HIGH:  rdata = 32'(src_req[HIGH_HI:HIGH_LO]);
      OFS_BRK_CTRL:   rdata = 32'(break_clear_enable);
      OFS_EVT_STATUS: rdata = 32'(evt_status);
      OFS_EVT_MASK:   rdata = 32'(evt_mask);
      OFS_MODE_STAT:  rdata = 32'({break_state, lp, pend});
      default: begin
        rdata  = 32'h0000_0000;
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite)
        prdata <= rdata;
    end
  end

  // Event status, mask and interrupt
  assign ev_set[EV_BREAK] = take && arb_kind == EX_BRK;
  assign ev_set[EV_WAIT]  = lp == LP_RUN && cpu_in.wait_exec;
  assign ev_set[EV_STOP]  = lp == LP_RUN && cpu_in.stop_exec && !cpu_in.wait_exec;
  assign ev_set[EV_WAKE]  = lp != LP_RUN && next_lp == LP_RUN;

  always_comb begin
    next_status = evt_status;
    // Clear only what the read returned, so a late event survives
    if (rd && paddr == OFS_EVT_STATUS)
      next_status = evt_status & ~prdata[EV_W-1:0];
    next_status = next_status | ev_set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_status <= '0;
      evt_mask   <= EVT_MASK_RST;
      irq        <= 1'b0;
    end else begin
      evt_status <= next_status;
      if (wr && paddr == OFS_EVT_MASK)
        evt_mask <= pwdata[EV_W-1:0];
      irq <= |(next_status & ((wr && paddr == OFS_EVT_MASK) ? pwdata[EV_W-1:0] : evt_mask));
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_mid_read;
    setup && !pwrite && paddr == OFS_PEND_MID;
  endsequence

  sequence s_high_read;
    setup && !pwrite && paddr == OFS_PEND_HIGH;
  endsequence

  sequence s_break_entry;
    brk_req && !break_state && !reset_any && kind == EX_NONE;
  endsequence

  AST_MID_FLAGS: assert property (s_mid_read |=> prdata == 32'($past(src_req[14:7])))
    else $error("mid pending flags wrong");
  AST_HIGH_FLAGS: assert property (s_high_read |=> prdata[6:0] == $past(src_req[21:15]))
    else $error("high pending flags wrong");
  AST_PEND_RO: assert property (s_high_read |=> prdata[31:7] == 25'h0 && !pslverr)
    else $error("pending register upper bits not zero");
  AST_RESET_TOP: assert property (reset_any |=> kind == EX_RST && vector == VEC_RESET)
    else $error("reset did not take top priority");
  AST_SRC_VECTOR: assert property (take && arb_kind == EX_HW && !reset_any
      |=> ((VEC_SRC1 - vector) >> 1) == 16'($past(hw_idx)) - 16'h0001)
    else $error("source vector address wrong");
  AST_BREAK_SWI: assert property (s_break_entry |=> break_state && vector == VEC_SWI && pend)
    else $error("break did not enter via software interrupt vector");
  AST_PROTECT: assert property (break_state && !break_clear_enable |-> !flag_clear_allow)
    else $error("flag clearing allowed in protected break");
  AST_CLEAR_OK: assert property (!break_state || break_clear_enable |-> flag_clear_allow)
    else $error("flag clearing blocked outside protection");
  AST_STANDBY: assert property (lp == LP_RUN && cpu_in.wait_exec |=> clock_hold && lp == LP_WAIT)
    else $error("wait did not enter standby");
  AST_CLR_MASK: assert property (lp == LP_RUN && (cpu_in.wait_exec || cpu_in.stop_exec)
      |=> clear_i_mask)
    else $error("interrupt mask not cleared on low power entry");
  AST_NO_PREEMPT: assert property (kind == EX_HW && !cpu_in.vec_ack && !reset_any && !i_clr_edge
      |=> kind == EX_HW && $stable(vector))
    else $error("latched request was preempted");
  AST_HIGHEST: assert property (take && arb_kind == EX_HW && src_req[1] && !reset_any
      |=> vector == VEC_SRC1)
    else $error("highest priority source not served first");

  AST_STOP_ENTRY: assert property (lp == LP_RUN && cpu_in.stop_exec && !cpu_in.wait_exec
      |=> clock_hold && lp == LP_STOP)
    else $error("stop did not enter standby");
  AST_WAKE: assert property (lp != LP_RUN && take |=> !clock_hold && lp == LP_RUN)
    else $error("latched exception did not wake the core");
  AST_HOLD_STAYS: assert property (lp != LP_RUN && !take |=> clock_hold && lp == $past(lp))
    else $error("standby left without an exception");
  AST_MASK_PULSE: assert property (clear_i_mask |=> !clear_i_mask)
    else $error("mask clear pulse longer than one cycle");
  AST_BREAK_EXIT: assert property (break_state && cpu_in.break_exit
      |=> !break_state && flag_clear_allow)
    else $error("flag clearing not restored after break");
  AST_RESET_NO_BREAK: assert property (reset_any |=> !break_state && pend)
    else $error("reset did not override break");
  AST_SWI_TAKEN: assert property (cpu_in.swi_exec && kind == EX_NONE && !reset_any
      && !(brk_req && !break_state) |=> kind == EX_SWI && vector == VEC_SWI)
    else $error("software interrupt not taken at its vector");
  AST_MASKED_IDLE: assert property (kind == EX_NONE && cpu_in.i_mask && !reset_any
      && !brk_req && !cpu_in.swi_exec |=> kind == EX_NONE)
    else $error("masked request was latched");
  AST_EVT_STICKY: assert property ((|ev_set) |=> (evt_status & $past(ev_set)) == $past(ev_set))
    else $error("event status bit lost");
  AST_UNMAPPED: assert property (setup && !pwrite && !mapped |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped read not refused");
endmodule : ipb_ctrl
`default_nettype wire

// ==== dv/ipb_cpu_model.sv ====
/*
 CPU core stand-in: runs instructions, fetches latched vectors after ack_dly cycles.
 Assumes clk and rst_n are shared with ipb_ctrl; the bench holds cmd for one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module ipb_cpu_model (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Bench control: 1 swi, 2 wait, 3 stop, 4 break exit, 5 return
  input  wire logic [2:0]            cmd,
  input  wire logic [2:0]            ack_dly,
  // Controller side
  input  wire ipb_pkg::ipb_cpu_out_t co,
  output ipb_pkg::ipb_cpu_in_t       ci,
  // Observation
  output logic [15:0]                last_vec,
  output logic [7:0]                 n_fetch
);
  import ipb_pkg::*;
  logic [2:0] cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ci       <= 7'h01;
      cnt      <= 3'h0;
      last_vec <= 16'h0000;
      n_fetch  <= 8'h00;
    end else begin
      // No instructions while held unclocked
      ci.instr_end  <= !ci.instr_end && !co.clock_hold;
      ci.swi_exec   <= (cmd == 3'h1);
      ci.wait_exec  <= (cmd == 3'h2);
      ci.stop_exec  <= (cmd == 3'h3);
      ci.break_exit <= (cmd == 3'h4);
      if (co.clear_i_mask || cmd == 3'h5) ci.i_mask <= 1'b0;
      // Vector fetch sets the mask, as interrupt entry does
      if (co.exc_pending && !ci.vec_ack && cnt >= ack_dly) begin
        ci.vec_ack <= 1'b1;
        ci.i_mask  <= 1'b1;
        last_vec   <= co.vector;
        n_fetch    <= n_fetch + 8'h01;
        cnt        <= 3'h0;
      end else begin
        ci.vec_ack <= 1'b0;
        cnt        <= co.exc_pending ? cnt + 3'h1 : 3'h0;
      end
    end
  end
endmodule : ipb_cpu_model
`default_nettype wire

// ==== dv/ipb_ctrl_tb.sv ====
/*
 Self-checking bench for ipb_ctrl: APB master, request sources and a CPU stand-in.
 Assumes ipb_pkg and ipb_cpu_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module ipb_ctrl_tb;
  import ipb_pkg::*;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         psel, penable, pwrite, pready, pslverr, brk_req, irq, fca, e;
  logic [7:0]   paddr, n_fetch;
  logic [31:0]  pwdata, prdata, q;
  logic [21:1]  src_req;
  logic [3:0]   reset_src;
  logic [2:0]   cmd, ack_dly;
  logic [15:0]  last_vec;
  ipb_cpu_in_t  ci;
  ipb_cpu_out_t co;
  int           seed = 18;
  int           miscompares = 0;
  int           total_checks = 0;

  always #2 clk = ~clk;

  ipb_ctrl dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_req(src_req),
    .reset_src(reset_src), .brk_req(brk_req), .cpu_in(ci), .cpu_out(co), .flag_clear_allow(fca), .irq(irq));
  ipb_cpu_model cpu (.clk(clk), .rst_n(rst_n), .cmd(cmd), .ack_dly(ack_dly), .co(co), .ci(ci),
    .last_vec(last_vec), .n_fetch(n_fetch));

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 50) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, pready, 1'b1);
      miscompares++;
      test_done();
    end
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, x);
  endtask : rd

  task automatic cpu_do(input logic [2:0] c);
    cmd <= c;
    @(posedge clk);
    cmd <= 3'h0;
    repeat (2) @(posedge clk);
  endtask : cpu_do

  task automatic wait_fetch;
    logic [7:0] n0;
    int n;
    n0 = n_fetch;
    n = 0;
    while (n_fetch === n0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n_fetch === n0) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, n_fetch, n0 + 8'h01);
      miscompares++;
      test_done();
    end
    @(posedge clk);
  endtask : wait_fetch

  function automatic logic [15:0] vec_of(input int n);
    return VEC_SRC1 - 16'(2 * (n - 1));
  endfunction : vec_of

  initial begin
    {psel, penable, pwrite, brk_req} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    src_req = '0;
    reset_src = 4'h0;
    cmd = 3'h0;
    ack_dly = 3'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(32'(co.vector), 32'(VEC_RESERVED));
    rd(OFS_MODE_STAT, 32'h0000_0002);
    rd(OFS_EVT_MASK, 32'h0000_0000);
    $display("test reset done");
    repeat (8) begin
      src_req <= 21'($random(seed));
      apb(1'b1, OFS_PEND_MID, $random(seed));
      rd(OFS_PEND_MID, {24'h0, src_req[14:7]});
      rd(OFS_PEND_HIGH, {25'h0, src_req[21:15]});
    end
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    $display("test pending flags done");
    for (int n = 1; n <= NUM_SRC; n++) begin
      ack_dly <= 3'($random(seed));
      src_req <= (21'($random(seed)) << n) | (21'h1 << (n - 1));
      cpu_do(3'h5);
      wait_fetch();
      chk(32'(last_vec), 32'(vec_of(n)));
    end
    ack_dly <= 3'h7;
    src_req <= 21'h10_0000;
    cpu_do(3'h5);
    repeat (4) @(posedge clk);
    src_req <= 21'h1F_FFFF;
    wait_fetch();
    chk(32'(last_vec), 32'h0000_FFD2);
    cpu_do(3'h1);
    wait_fetch();
    chk(32'(last_vec), 32'(VEC_SWI));
    for (int k = 0; k < RST_SRC_W; k++) begin
      cpu_do(3'h5);
      reset_src <= 4'(1 << k);
      @(posedge clk);
      reset_src <= 4'h0;
      wait_fetch();
      chk(32'(last_vec), 32'(VEC_RESET));
    end
    src_req <= '0;
    $display("test priority done");
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, OFS_BRK_CTRL, 32'(b));
      apb(1'b1, OFS_EVT_MASK, 32'(b));
      brk_req <= 1'b1;
      @(posedge clk);
      brk_req <= 1'b0;
      wait_fetch();
      chk(32'(last_vec), 32'(VEC_SWI));
      chk(32'({co.break_state, fca, irq}), 32'({1'b1, b[0], b[0]}));
      rd(OFS_MODE_STAT, 32'h0000_0012);
      rd(OFS_EVT_STATUS, 32'h0000_0001);
      rd(OFS_EVT_STATUS, 32'h0000_0000);
      cpu_do(3'h4);
      chk(32'({co.break_state, fca}), 32'h0000_0001);
    end
    $display("test break done");
    for (int w = 0; w < 2; w++) begin
      cpu_do(3'h2 + 3'(w));
      rd(OFS_MODE_STAT, 32'(4 << w));
      chk(32'({co.clock_hold, ci.i_mask}), 32'h0000_0002);
      src_req <= 21'h00_0001;
      wait_fetch();
      chk(32'({co.clock_hold, last_vec}), 32'(VEC_SRC1));
      rd(OFS_EVT_STATUS, 32'(2 << w) | 32'h0000_0008);
      src_req <= '0;
    end
    $display("test low power done");
    test_done();
  end
endmodule : ipb_ctrl_tb
`default_nettype wire
